// ### design/ttc_talkback.sv
/*
 * Talkback tone control channel: button handling, tone generation,
 * main output muting, received tone detection, dimming and LEDs.
 * Assumes synchronous inputs, one sample strobe per 48 kHz frame.
 */
// Notes on behaviour
// R01: Five functions: talk, pilot, call, tone, disabled.
// R02: Talk mode sends microphone audio out.
// R03: Pilot mode adds 18 kHz at -20 dBFS.
// R04: Call adds 20 kHz to active talk channels.
// R05: Tone-only sends just 20 kHz, no microphone.
// R06: Disabled function affects nothing else.
// R07: Disabled tap flashes red LED four times.
// R08: Disabled held button flashes red continuously.
// R09: Main output setting: no effect or mute.
// R10: Mute setting silences main mic when active.
// R11: No-effect setting keeps main mic always.
// R12: Detect setting: none, call light, cue dim.
// R13: Valid tone is sustained, about 15 kHz up.
// R14: Detector never latches after tone ends.
// R15: Call light flashes knob yellow while detected.
// R16: Display flashes orange, five times at most.
// R17: Low-pass removes tone before headphone routing.
// R18: Cue mode dims routed main audio on tone.
// R19: Dim releases as soon as tone ends.
// R20: Dim is fixed 15 dB.
// R21: Hybrid button: hold momentary, tap toggles.
// R22: Talkback input routes left, right or both.
// R23: Tone sums saturate instead of wrapping.
`timescale 1ns/10ps
`default_nettype none

// --------------------------------------------------------------------
// Sample FIFO
// --------------------------------------------------------------------
module ttc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	assign in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rd_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (clk_en && push) begin
			mem_r[wr_r] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else if (clk_en) begin
			if (push) begin
				wr_r <= wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= rd_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // ttc_fifo

// --------------------------------------------------------------------
// LED flasher: N flashes, or endless while asked
// --------------------------------------------------------------------
module ttc_flasher #(
	parameter int N = 4,
	parameter int HALF = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic start,
	input wire logic run,
	input wire logic endless,
	output logic lit
);
	logic act_r;
	logic on_r;
	logic [2:0] left_r;
	logic [24:0] cnt_r;

	assign lit = act_r && on_r;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			act_r <= 1'b0;
			on_r <= 1'b0;
			left_r <= '0;
			cnt_r <= '0;
		end else if (clk_en) begin
			if (start) begin
				act_r <= 1'b1;
				on_r <= 1'b1;
				left_r <= 3'(N);
				cnt_r <= '0;
			end else if (!run) begin
				act_r <= 1'b0;
			end else if (act_r) begin
				if (cnt_r == 25'(HALF - 1)) begin
					cnt_r <= '0;
					on_r <= !on_r;
					if (on_r && !endless) begin
						left_r <= left_r - 3'h1;
						if (left_r == 3'h1) begin
							act_r <= 1'b0;
						end
					end
				end else begin
					cnt_r <= cnt_r + 25'h0000001;
				end
			end
		end
	end

	a_flash_count: assert property (@(posedge clk) disable iff (!reset_n) // R16
		left_r <= 3'(N)) else $error("flash count above its limit");
endmodule // ttc_flasher

// --------------------------------------------------------------------
// Channel top
// --------------------------------------------------------------------
module ttc_talkback #(
	parameter int HOLD_CYCLES = ttc_pkg::HOLD_CYC,
	parameter int FLASH_HALF_CYCLES = ttc_pkg::FLASH_HALF_CYC
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic sample_stb,
	input wire ttc_pkg::ttc_func_t func_sel,
	input wire logic main_mute_sel,
	input wire ttc_pkg::ttc_detect_t detect_sel,
	input wire logic [1:0] route_sel,
	input wire logic button,
	input wire logic call_in,
	input wire logic signed [15:0] mic_in,
	input wire logic signed [15:0] main_l_in,
	input wire logic signed [15:0] main_r_in,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [15:0] rx_data,
	output logic signed [15:0] tb_out,
	output logic signed [15:0] main_out,
	output logic signed [15:0] phones_l,
	output logic signed [15:0] phones_r,
	output logic out_valid,
	output logic call_out,
	output logic led_green,
	output logic led_red,
	output logic knob_yellow,
	output logic display_orange,
	output logic tone_detected,
	output logic talent_cue_dim
);
	logic btn_prev_r;
	logic latch_r;
	logic [24:0] hold_r;
	logic active;
	logic disabled;
	logic [4:0] ph18_r;
	logic [4:0] ph20_r;
	logic signed [15:0] t18;
	logic signed [15:0] t20;
	logic signed [17:0] tb_sum;
	logic signed [15:0] tb_nxt;
	logic take;
	logic rx_out_valid;
	logic [15:0] rx_word;
	logic signed [15:0] x1_r;
	logic signed [15:0] x2_r;
	logic signed [17:0] lp_sum;
	logic signed [15:0] lp_r;
	logic signed [16:0] diff;
	logic [16:0] mag;
	logic [20:0] env_r;
	logic [20:0] env_nxt;
	logic [7:0] run_r;
	logic cue_cond;
	logic cue_prev_r;
	logic [12:0] gain_l;
	logic [12:0] gain_r;
	logic signed [29:0] prod_l;
	logic signed [29:0] prod_r;

	function automatic logic signed [15:0] sine(input logic [4:0] p);
		logic [4:0] k;
		logic [4:0] q;
		logic [15:0] m;
		k = (p >= 5'h0C) ? p - 5'h0C : p;
		q = (k > 5'h06) ? 5'h0C - k : k;
		unique case (q)
			5'h00: m = 16'h0000;
			5'h01: m = 16'h0350;
			5'h02: m = 16'h0667;
			5'h03: m = 16'h090D;
			5'h04: m = 16'h0B16;
			5'h05: m = 16'h0C5D;
			default: m = 16'h0CCD;
		endcase
		return (p >= 5'h0C) ? -$signed(m) : $signed(m);
	endfunction

	function automatic logic signed [15:0] sat(input logic signed [17:0] v);
		if (v > 18'sh07FFF) begin
			return 16'sh7FFF;
		end else if (v < -18'sh08000) begin
			return 16'sh8000;
		end
		return v[15:0];
	endfunction

	function automatic logic [4:0] step(input logic [4:0] p, input logic [4:0] s);
		logic [5:0] n;
		n = {1'b0, p} + {1'b0, s};
		return (n > {1'b0, ttc_pkg::PHASE_LAST}) ? 5'(n - 6'(ttc_pkg::SINE_STEPS)) : n[4:0];
	endfunction

	// ----------------------------------------------------------------
	// Hybrid button
	// ----------------------------------------------------------------
	assign disabled = (func_sel == ttc_pkg::TTC_FN_DISABLED);
	assign active = (button || latch_r) && !disabled; // R06
	assign call_out = active && (func_sel == ttc_pkg::TTC_FN_CALL);
	assign led_green = active;

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			btn_prev_r <= 1'b0;
			latch_r <= 1'b0;
			hold_r <= '0;
		end else if (clk_en) begin
			btn_prev_r <= button;
			if (disabled) begin
				latch_r <= 1'b0; // R06
			end else if (btn_prev_r && !button) begin
				latch_r <= (hold_r < 25'(HOLD_CYCLES)) ? !latch_r : 1'b0; // R21
			end
			if (button && !btn_prev_r) begin
				hold_r <= '0;
			end else if (button && hold_r < 25'(HOLD_CYCLES)) begin
				hold_r <= hold_r + 25'h0000001;
			end
		end
	end

	ttc_flasher #(.N(ttc_pkg::DIS_FLASHES), .HALF(FLASH_HALF_CYCLES)) u_red (
		.clk(core_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.start(disabled && button && !btn_prev_r), // R07
		.run(disabled),
		.endless(button), // R08
		.lit(led_red)
	);

	// ----------------------------------------------------------------
	// Tone generation and outgoing audio
	// ----------------------------------------------------------------
	assign t18 = sine(ph18_r);
	assign t20 = sine(ph20_r);

	always_comb begin
		tb_sum = '0;
		if (active) begin
			unique case (func_sel)
				ttc_pkg::TTC_FN_TALK: tb_sum = 18'(mic_in) + (call_in ? 18'(t20) : 18'sh0); // R02 R04
				ttc_pkg::TTC_FN_PILOT: tb_sum = 18'(mic_in) + 18'(t18) + (call_in ? 18'(t20) : 18'sh0); // R03 R04
				ttc_pkg::TTC_FN_TONE_ONLY: tb_sum = 18'(t20); // R05
				default: tb_sum = '0; // R01
			endcase
		end
		tb_nxt = sat(tb_sum); // R23
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ph18_r <= '0;
			ph20_r <= '0;
			tb_out <= '0;
			main_out <= '0;
			out_valid <= 1'b0;
		end else if (clk_en) begin
			out_valid <= sample_stb;
			if (sample_stb) begin
				ph18_r <= step(ph18_r, ttc_pkg::PILOT_STEP);
				ph20_r <= step(ph20_r, ttc_pkg::CALL_STEP);
				tb_out <= tb_nxt;
				main_out <= (main_mute_sel && active) ? 16'sh0000 : mic_in; // R09 R10 R11
			end
		end
	end

	a_disabled_quiet: assert property (@(posedge core_clk) disable iff (!reset_n) // R06
		(clk_en && sample_stb && disabled) |=> (tb_out == 16'sh0000 && main_out == $past(mic_in)))
		else $error("disabled function touched audio");
	a_talk_mic: assert property (@(posedge core_clk) disable iff (!reset_n) // R02
		(clk_en && sample_stb && active && !call_in && func_sel == ttc_pkg::TTC_FN_TALK)
		|=> tb_out == $past(mic_in)) else $error("talk output is not microphone");
	a_tone_only: assert property (@(posedge core_clk) disable iff (!reset_n) // R05
		(clk_en && sample_stb && active && func_sel == ttc_pkg::TTC_FN_TONE_ONLY)
		|=> tb_out == $past(t20)) else $error("tone-only output carries other audio");
	a_main_mute: assert property (@(posedge core_clk) disable iff (!reset_n) // R10
		(clk_en && sample_stb && main_mute_sel && active) |=> main_out == 16'sh0000)
		else $error("main mic not muted during talkback");
	a_main_keep: assert property (@(posedge core_clk) disable iff (!reset_n) // R11
		(clk_en && sample_stb && !main_mute_sel) |=> main_out == $past(mic_in))
		else $error("main mic altered with no-effect setting");
	a_tap_toggle: assert property (@(posedge core_clk) disable iff (!reset_n) // R21
		(clk_en && btn_prev_r && !button && !disabled && hold_r < 25'(HOLD_CYCLES))
		|=> latch_r != $past(latch_r)) else $error("tap did not toggle function");

	// ----------------------------------------------------------------
	// Received talkback: buffer, low-pass and tone detector
	// ----------------------------------------------------------------
	ttc_fifo #(.WIDTH(ttc_pkg::SAMPLE_W), .DEPTH(ttc_pkg::FIFO_DEPTH)) u_rx_fifo (
		.clk(core_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.in_valid(rx_valid),
		.in_ready(rx_ready),
		.in_data(rx_data),
		.out_valid(rx_out_valid),
		.out_ready(sample_stb),
		.out_data(rx_word)
	);

	assign take = clk_en && sample_stb && rx_out_valid;
	assign lp_sum = 18'($signed(rx_word)) + 18'(x1_r) + 18'(x1_r) + 18'(x2_r); // R17
	assign diff = 17'($signed(rx_word)) - 17'(x1_r); // R13
	assign mag = diff[16] ? 17'(-diff) : 17'(diff);
	assign env_nxt = env_r - (env_r >> 4) + 21'(mag);

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			x1_r <= '0;
			x2_r <= '0;
			lp_r <= '0;
			env_r <= '0;
			run_r <= '0;
			tone_detected <= 1'b0;
		end else if (take) begin
			x1_r <= $signed(rx_word);
			x2_r <= x1_r;
			lp_r <= lp_sum[17:2]; // R17
			env_r <= env_nxt;
			if (env_nxt < ttc_pkg::ENV_THRESH) begin
				run_r <= '0;
				tone_detected <= 1'b0; // R14
			end else if (run_r < ttc_pkg::DET_ON_SAMPLES) begin
				run_r <= run_r + 8'h01;
			end else begin
				tone_detected <= 1'b1; // R13
			end
		end
	end

	a_no_latch: assert property (@(posedge core_clk) disable iff (!reset_n) // R14
		(take && env_nxt < ttc_pkg::ENV_THRESH) |=> !tone_detected)
		else $error("detector held after tone ended");

	// ----------------------------------------------------------------
	// Call light and talent cue dim
	// ----------------------------------------------------------------
	assign cue_cond = tone_detected && (detect_sel == ttc_pkg::TTC_DET_CALL_LIGHT); // R12

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			cue_prev_r <= 1'b0;
		end else if (clk_en) begin
			cue_prev_r <= cue_cond;
		end
	end

	ttc_flasher #(.N(1), .HALF(FLASH_HALF_CYCLES)) u_knob (
		.clk(core_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.start(cue_cond && !cue_prev_r),
		.run(cue_cond), // R15
		.endless(1'b1),
		.lit(knob_yellow)
	);

	ttc_flasher #(.N(ttc_pkg::CUE_FLASHES), .HALF(FLASH_HALF_CYCLES)) u_disp (
		.clk(core_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.start(cue_cond && !cue_prev_r), // R16
		.run(cue_cond),
		.endless(1'b0),
		.lit(display_orange)
	);

	assign talent_cue_dim = tone_detected && (detect_sel == ttc_pkg::TTC_DET_CUE_DIM); // R18 R19
	assign gain_l = (talent_cue_dim && route_sel[ttc_pkg::ROUTE_LEFT_BIT]) ?
		ttc_pkg::DIM_GAIN_Q12 : ttc_pkg::UNITY_GAIN_Q12; // R20
	assign gain_r = (talent_cue_dim && route_sel[ttc_pkg::ROUTE_RIGHT_BIT]) ?
		ttc_pkg::DIM_GAIN_Q12 : ttc_pkg::UNITY_GAIN_Q12; // R20
	assign prod_l = main_l_in * $signed({1'b0, gain_l});
	assign prod_r = main_r_in * $signed({1'b0, gain_r});

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			phones_l <= '0;
			phones_r <= '0;
		end else if (clk_en && sample_stb) begin
			phones_l <= sat(prod_l[29:12] +
				(route_sel[ttc_pkg::ROUTE_LEFT_BIT] ? 18'(lp_r) : 18'sh0)); // R22
			phones_r <= sat(prod_r[29:12] +
				(route_sel[ttc_pkg::ROUTE_RIGHT_BIT] ? 18'(lp_r) : 18'sh0)); // R22
		end
	end

	a_dim_release: assert property (@(posedge core_clk) disable iff (!reset_n) // R19
		(clk_en && sample_stb && !talent_cue_dim && !route_sel[ttc_pkg::ROUTE_LEFT_BIT])
		|=> phones_l == $past(main_l_in))
		else $error("main audio not restored after tone");
	a_knob_follow: assert property (@(posedge core_clk) disable iff (!reset_n) // R15
		knob_yellow |-> $past(cue_cond)) else $error("knob flashes without detected tone");
endmodule // ttc_talkback

`default_nettype wire

// ### inc/ttc_pkg.sv
/*
 * Shared constants and types for the talkback tone control channel.
 * Assumes a 50 MHz core clock and a 48 kHz sample strobe.
 */
`default_nettype none
package ttc_pkg;

	// ----------------------------------------------------------------
	// Function, detect and routing codes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		TTC_FN_TALK = 3'h0,
		TTC_FN_PILOT = 3'h1,
		TTC_FN_CALL = 3'h2,
		TTC_FN_TONE_ONLY = 3'h3,
		TTC_FN_DISABLED = 3'h4
	} ttc_func_t;

	typedef enum logic [1:0] {
		TTC_DET_NONE = 2'h0,
		TTC_DET_CALL_LIGHT = 2'h1,
		TTC_DET_CUE_DIM = 2'h2
	} ttc_detect_t;

	localparam int ROUTE_LEFT_BIT = 0;
	localparam int ROUTE_RIGHT_BIT = 1;

	// ----------------------------------------------------------------
	// Audio constants
	// ----------------------------------------------------------------
	localparam int SAMPLE_W = 16;
	localparam int SAMPLE_RATE_HZ = 48000;
	localparam int SINE_STEPS = 24;
	localparam int PILOT_HZ = 18000;
	localparam int CALL_HZ = 20000;
	localparam logic [4:0] PILOT_STEP = 5'(PILOT_HZ * SINE_STEPS / SAMPLE_RATE_HZ);
	localparam logic [4:0] CALL_STEP = 5'(CALL_HZ * SINE_STEPS / SAMPLE_RATE_HZ);
	localparam logic [4:0] PHASE_LAST = 5'(SINE_STEPS - 1);
	localparam logic [12:0] DIM_GAIN_Q12 = 13'h02D8;
	localparam logic [12:0] UNITY_GAIN_Q12 = 13'h1000;
	localparam logic [20:0] ENV_THRESH = 21'h004000;
	localparam logic [7:0] DET_ON_SAMPLES = 8'h30;
	localparam int FIFO_DEPTH = 16;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50000000;
	localparam int FLASH_HALF_MS = 125;
	localparam int HOLD_MS = 400;
	localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
	localparam int HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
	localparam int DIS_FLASHES = 4;
	localparam int CUE_FLASHES = 5;

endpackage
`default_nettype wire

// ### test/testbench.sv
/*
 * Self-checking bench for the talkback channel top.
 * Assumes the package and the far-side model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module testbench;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam int GAP = 20;
	logic core_clk, reset_n, clk_en, sample_stb, main_mute_sel, button, call_in;
	ttc_pkg::ttc_func_t func_sel;
	ttc_pkg::ttc_detect_t detect_sel;
	logic [1:0] route_sel;
	logic signed [15:0] mic_in, main_l_in, main_r_in, tb_out, main_out, phones_l, phones_r;
	logic [15:0] rx_data, sent;
	logic rx_valid, rx_ready, out_valid, call_out, led_green, led_red, knob_yellow;
	logic display_orange, tone_detected, talent_cue_dim, m_en, m_tone, red_q, orng_q, knob_q;
	logic [3:0] m_gap;
	logic signed [16:0] pk, mx, mn, v;
	int n_errors, tests_run, n_red, n_orng, n_knob;

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	ttc_talkback #(.HOLD_CYCLES(20), .FLASH_HALF_CYCLES(4)) i_dut (.core_clk(core_clk),
		.reset_n(reset_n), .clk_en(clk_en), .sample_stb(sample_stb), .func_sel(func_sel),
		.main_mute_sel(main_mute_sel), .detect_sel(detect_sel), .route_sel(route_sel),
		.button(button), .call_in(call_in), .mic_in(mic_in), .main_l_in(main_l_in),
		.main_r_in(main_r_in), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
		.tb_out(tb_out), .main_out(main_out), .phones_l(phones_l), .phones_r(phones_r),
		.out_valid(out_valid), .call_out(call_out), .led_green(led_green), .led_red(led_red),
		.knob_yellow(knob_yellow), .display_orange(display_orange),
		.tone_detected(tone_detected), .talent_cue_dim(talent_cue_dim));

	ttc_net_model i_net (.clk(core_clk), .reset_n(reset_n), .enable(m_en), .tone_on(m_tone),
		.gap(m_gap), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .sent(sent));

	// Rising-edge counters for the indicator outputs
	always @(posedge core_clk) begin
		if (led_red && !red_q) n_red++;
		if (display_orange && !orng_q) n_orng++;
		if (knob_yellow && !knob_q) n_knob++;
		red_q <= led_red;
		orng_q <= display_orange;
		knob_q <= knob_yellow;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic chk_bit(input string nm, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %b seen %b", nm, exp, got);
		end
	endtask

	task automatic chk_word(input string nm, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Strobes n frames, tracking peak magnitude, max and min of tb_out
	task automatic run_stb(input int n);
		pk = 17'sh00000;
		mx = -17'sh10000;
		mn = 17'sh0FFFF;
		repeat (n) begin
			sample_stb = 1'b1;
			tick(1);
			sample_stb = 1'b0;
			chk_bit("out_valid", 1'b1, out_valid);
			v = tb_out;
			if (v > mx) mx = v;
			if (v < mn) mn = v;
			if (v < 0) v = -v;
			if (v > pk) pk = v;
			tick(GAP - 1);
		end
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_fifo();
		m_gap = 4'h0;
		m_en = 1'b1;
		tick(30);
		chk_bit("rx_ready full", 1'b0, rx_ready);
		chk_word("words in", 16'h0010, sent);
		m_en = 1'b0;
		run_stb(16);
		chk_bit("rx_ready drained", 1'b1, rx_ready);
		m_en = 1'b1;
		tick(30);
		chk_word("words refill", 16'h0020, sent);
		m_en = 1'b0;
		run_stb(20);
		$display("done fifo");
	endtask

	task automatic t_modes();
		ttc_pkg::ttc_func_t fl[5];
		logic [15:0] ep[5];
		fl = '{ttc_pkg::TTC_FN_TALK, ttc_pkg::TTC_FN_PILOT, ttc_pkg::TTC_FN_CALL,
			ttc_pkg::TTC_FN_TONE_ONLY, ttc_pkg::TTC_FN_DISABLED};
		// Tone peak is -20 dBFS of full scale
		ep = '{16'h0000, 16'h0CCD, 16'h0000, 16'h0CCD, 16'h0000};
		for (int i = 0; i < 5; i++) begin
			func_sel = fl[i];
			button = 1'b1;
			run_stb(24);
			chk_word("tone peak", ep[i], pk[15:0]);
			chk_bit("call_out", fl[i] == ttc_pkg::TTC_FN_CALL, call_out);
			button = 1'b0;
			tick(60);
		end
		$display("done modes");
	endtask

	task automatic t_sat();
		func_sel = ttc_pkg::TTC_FN_TALK;
		call_in = 1'b1;
		button = 1'b1;
		run_stb(24);
		chk_word("call peak", 16'h0CCD, pk[15:0]);
		mic_in = 16'sh7FFF;
		run_stb(24);
		chk_word("sat max", 16'h7FFF, mx[15:0]);
		chk_bit("no wrap", 1'b1, mn >= 17'sh07332);
		call_in = 1'b0;
		func_sel = ttc_pkg::TTC_FN_TONE_ONLY;
		run_stb(24);
		chk_word("tone only peak", 16'h0CCD, pk[15:0]);
		button = 1'b0;
		mic_in = 16'sh0000;
		tick(10);
		$display("done saturate");
	endtask

	task automatic t_talk();
		func_sel = ttc_pkg::TTC_FN_TALK;
		mic_in = 16'sh1234;
		main_mute_sel = 1'b1;
		button = 1'b1;
		run_stb(1);
		chk_word("tb_out talk", 16'h1234, tb_out);
		chk_word("main muted", 16'h0000, main_out);
		main_mute_sel = 1'b0;
		run_stb(1);
		chk_word("main kept active", 16'h1234, main_out);
		button = 1'b0;
		main_mute_sel = 1'b1;
		run_stb(1);
		chk_word("tb_out idle", 16'h0000, tb_out);
		chk_word("main idle", 16'h1234, main_out);
		mic_in = 16'sh0F0F;
		clk_en = 1'b0;
		sample_stb = 1'b1;
		tick(2);
		sample_stb = 1'b0;
		chk_bit("frozen valid", 1'b0, out_valid);
		chk_word("frozen main", 16'h1234, main_out);
		clk_en = 1'b1;
		$display("done talk");
	endtask

	task automatic t_hybrid();
		func_sel = ttc_pkg::TTC_FN_TALK;
		button = 1'b1;
		tick(5);
		button = 1'b0;
		tick(5);
		chk_bit("tap on", 1'b1, led_green);
		button = 1'b1;
		tick(5);
		button = 1'b0;
		tick(5);
		chk_bit("tap off", 1'b0, led_green);
		button = 1'b1;
		tick(40);
		chk_bit("held", 1'b1, led_green);
		button = 1'b0;
		tick(3);
		chk_bit("hold released", 1'b0, led_green);
		$display("done hybrid");
	endtask

	task automatic t_disabled();
		func_sel = ttc_pkg::TTC_FN_DISABLED;
		mic_in = 16'sh1111;
		n_red = 0;
		button = 1'b1;
		tick(3);
		button = 1'b0;
		tick(60);
		chk_bit("four flashes", 1'b1, n_red == 4);
		n_red = 0;
		button = 1'b1;
		run_stb(1);
		chk_word("main untouched", 16'h1111, main_out);
		chk_word("tb_out silent", 16'h0000, tb_out);
		chk_bit("green off", 1'b0, led_green);
		tick(100);
		chk_bit("endless flash", 1'b1, n_red >= 10);
		button = 1'b0;
		tick(80);
		$display("done disabled");
	endtask

	task automatic t_call_light();
		detect_sel = ttc_pkg::TTC_DET_CALL_LIGHT;
		m_gap = 4'h3;
		m_tone = 1'b1;
		m_en = 1'b1;
		n_orng = 0;
		n_knob = 0;
		run_stb(120);
		chk_bit("detected", 1'b1, tone_detected);
		chk_bit("no dim", 1'b0, talent_cue_dim);
		chk_bit("knob flashing", 1'b1, n_knob > 5);
		m_tone = 1'b0;
		run_stb(100);
		chk_bit("not latched", 1'b0, tone_detected);
		chk_bit("knob off", 1'b0, knob_yellow);
		chk_bit("display limit", 1'b1, n_orng == 5);
		$display("done call light");
	endtask

	task automatic t_cue_dim();
		detect_sel = ttc_pkg::TTC_DET_CUE_DIM;
		route_sel = 2'h1;
		main_l_in = 16'sh4000;
		main_r_in = 16'sh4000;
		m_tone = 1'b1;
		run_stb(120);
		chk_bit("dim on", 1'b1, talent_cue_dim);
		// 0x4000 times 728/4096 is 0x0B60; the filtered tone cancels
		chk_bit("left dimmed", 1'b1, phones_l > 16'sh0B5B && phones_l < 16'sh0B65);
		chk_word("right kept", 16'h4000, phones_r);
		route_sel = 2'h2;
		run_stb(3);
		chk_word("left kept", 16'h4000, phones_l);
		chk_bit("right dimmed", 1'b1, phones_r > 16'sh0B5B && phones_r < 16'sh0B65);
		m_tone = 1'b0;
		run_stb(100);
		chk_bit("dim off", 1'b0, talent_cue_dim);
		chk_word("right restored", 16'h4000, phones_r);
		$display("done cue dim");
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		n_errors = 0;
		tests_run = 0;
		{reset_n, sample_stb, main_mute_sel, button, call_in, m_en, m_tone} = 7'h00;
		clk_en = 1'b1;
		func_sel = ttc_pkg::TTC_FN_TALK;
		detect_sel = ttc_pkg::TTC_DET_NONE;
		route_sel = 2'h3;
		{mic_in, main_l_in, main_r_in} = 48'h0;
		m_gap = 4'h0;
		tick(20);
		reset_n = 1'b1;
		chk_bit("rx_ready reset", 1'b1, rx_ready);
		chk_word("tb_out reset", 16'h0000, tb_out);
		chk_bit("green reset", 1'b0, led_green);
		t_fifo();
		t_modes();
		t_sat();
		t_talk();
		t_hybrid();
		t_disabled();
		t_call_light();
		t_cue_dim();
		conclude();
	end

	initial begin
		repeat (60000) @(posedge core_clk);
		n_errors++;
		$display("BAD watchdog expected done seen hang");
		conclude();
	end
endmodule // testbench

`default_nettype wire

// ### test/ttc_net_model.sv
/*
 * Far-side model of the networked talkback receive channel.
 * Assumes the block's rx handshake: a word moves on an edge with valid and ready high.
 */
`timescale 1ns/10ps
`default_nettype none

module ttc_net_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic tone_on,
	input wire logic [3:0] gap,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [15:0] rx_data,
	output logic [15:0] sent
);
	// ----------------------------------------------------------------
	// Word source: alternating +/-0x2000 quarter-scale swing, far above the detect band edge
	// ----------------------------------------------------------------
	logic [3:0] wait_r;
	logic phase_r;
	logic [15:0] word;

	assign word = !tone_on ? 16'h0000 : (phase_r ? 16'h2000 : 16'hE000);

	// ----------------------------------------------------------------
	// Handshake: hold the word until taken, then pause gap cycles
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rx_valid <= 1'b0;
			rx_data <= 16'h0000;
			sent <= 16'h0000;
			wait_r <= 4'h0;
			phase_r <= 1'b0;
		end else if (rx_valid && rx_ready) begin
			sent <= sent + 16'h0001;
			wait_r <= gap;
			if (gap == 4'h0 && enable) begin
				rx_data <= word;
				phase_r <= !phase_r;
			end else begin
				// Released data must not look like a held word
				rx_valid <= 1'b0;
				rx_data <= ~rx_data;
			end
		end else if (!rx_valid && enable) begin
			if (wait_r != 4'h0) begin
				wait_r <= wait_r - 4'h1;
			end else begin
				rx_valid <= 1'b1;
				rx_data <= word;
				phase_r <= !phase_r;
			end
		end
	end
endmodule // ttc_net_model

`default_nettype wire
